// [rtl/ddf_pkg.sv]
// Constants, register map and state encoding of the memory-backed deep FIFO.
// Assumes one 125 MHz system clock.
package ddf_pkg;
  // Word store and memory bursts
  localparam int DATA_W = 32;
  localparam int ADDR_W = 25;
  localparam int PTR_W = 26;
  localparam int BUF_WORDS = 33554432;
  localparam logic [PTR_W-1:0] BUF_FULL_LEVEL = 26'h2000000;
  localparam logic [PTR_W-1:0] BURST_WORDS = 26'h0000004;
  localparam int ROW_BITS = 9;

  // Staging FIFO depths
  localparam int STAGE_ASYNC_DEPTH = 15;
  localparam int STAGE_EDGE_DEPTH = 16;

  // Register bus
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] REG_LEVEL = 8'h08;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_LED_EMPTY_BIT = 3;
  localparam int STAT_LED_FULL_BIT = 4;

  // Indicator timing
  localparam int SYS_CLK_KHZ = 125000;
  localparam int LED_HOLD_MS = 50;
  localparam int HEARTBEAT_HALF_MS = 250;
  localparam int LED_HOLD_CYCLES = LED_HOLD_MS * SYS_CLK_KHZ;
  localparam int HEARTBEAT_HALF_CYCLES = HEARTBEAT_HALF_MS * SYS_CLK_KHZ;

  typedef enum logic [1:0] {
    DDF_S_IDLE,
    DDF_S_WR_HEAD,
    DDF_S_WR_TAIL,
    DDF_S_RD
  } ddf_state_t;

  typedef enum logic [1:0] {
    DDF_REG_CTRL,
    DDF_REG_STATUS,
    DDF_REG_LEVEL,
    DDF_REG_NONE
  } ddf_reg_t;
endpackage

// [rtl/ddf_stage_fifo.sv]
// Small staging FIFO with valid/ready on both sides and a level output.
// Assumes one clock; clk_en low freezes it and blocks both handshakes.
`timescale 1ns/10ps
`default_nettype none
module ddf_stage_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input wire logic rd_ready,
  output logic [LW-1:0] level
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);
  localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [IW-1:0] wr_idx;
  logic [IW-1:0] rd_idx;
  logic push;
  logic pop;

  assign wr_ready = clk_en && (level != FULL_LEVEL);
  assign rd_valid = clk_en && (level != '0);
  assign rd_data = mem[rd_idx];
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;

  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      level <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_idx <= (wr_idx == LAST_IDX) ? '0 : IW'(wr_idx + 1'b1);
      end
      if (pop) begin
        rd_idx <= (rd_idx == LAST_IDX) ? '0 : IW'(rd_idx + 1'b1);
      end
      if (push && !pop) begin
        level <= LW'(level + 1'b1);
      end else if (pop && !push) begin
        level <= LW'(level - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/ddf_top.sv]
// Deep 32-bit FIFO kept in an external double-data-rate bank, with staging FIFOs and LEDs.
// Assumes every port is on the one sys_clk.
//
// Behaviour
// - Whole memory bank serves as one buffer of 32M words, 32 bits each.
// - Every channel 0 input word enters the buffer; every output word leaves to channel 0.
// - Ingress passes a 15x32 FIFO then rise and fall FIFOs feeding memory.
// - Egress passes rise and fall FIFOs then a 15x32 FIFO toward channel 0.
// - LED 0 lights while the buffer holds no words.
// - LED 1 lights while the buffer has no free locations.
// - Each of those LEDs has a counter stretching short events visibly.
// - LED 4 flashes continuously as a heartbeat of the channel clock.
// - Memory-side clocks come from 200 MHz derived from a 50 MHz oscillator; the code runs memory-side logic on the one 125 MHz sys_clk.
// - Channel FIFO clocks come straight from a separate 100 MHz oscillator; the code clocks the channel FIFOs from sys_clk.
// - Shared-clock option clocks input and output channels from one clock.
// - Accesses open a row, transfer, then close it when done.
// - Move many words per open row to keep row overhead small.
// - Memory link moves one word per rising and one per falling edge.
// - Separate rise and fall data FIFOs carry write and read data.
// - Writes use address, rise, fall FIFOs; reads address plus rise, fall returns.
// - Each burst moves four words: two rising and two falling.
// - Ingress words go alternately to the rise FIFO then the fall FIFO.
// - Memory reads and writes never happen at the same time.
`timescale 1ns/10ps
`default_nettype none
module ddf_top #(
  parameter int unsigned LED_HOLD = ddf_pkg::LED_HOLD_CYCLES,
  parameter int unsigned HEARTBEAT_HALF = ddf_pkg::HEARTBEAT_HALF_CYCLES,
  parameter int ASYNC_DEPTH = ddf_pkg::STAGE_ASYNC_DEPTH,
  parameter int EDGE_DEPTH = ddf_pkg::STAGE_EDGE_DEPTH
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ddf_pkg::REG_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic in_valid,
  input wire logic [ddf_pkg::DATA_W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [ddf_pkg::DATA_W-1:0] out_data,
  input wire logic out_ready,
  output logic wr_addr_valid,
  output logic [ddf_pkg::ADDR_W-1:0] wr_addr,
  input wire logic wr_addr_ready,
  output logic wr_rise_valid,
  output logic [ddf_pkg::DATA_W-1:0] wr_rise_data,
  input wire logic wr_rise_ready,
  output logic wr_fall_valid,
  output logic [ddf_pkg::DATA_W-1:0] wr_fall_data,
  input wire logic wr_fall_ready,
  output logic rd_addr_valid,
  output logic [ddf_pkg::ADDR_W-1:0] rd_addr,
  input wire logic rd_addr_ready,
  input wire logic rd_rise_valid,
  input wire logic [ddf_pkg::DATA_W-1:0] rd_rise_data,
  output logic rd_rise_ready,
  input wire logic rd_fall_valid,
  input wire logic [ddf_pkg::DATA_W-1:0] rd_fall_data,
  output logic rd_fall_ready,
  output logic led_empty,
  output logic led_full,
  output logic led_heartbeat
);
  localparam int DW = ddf_pkg::DATA_W;
  localparam int PW = ddf_pkg::PTR_W;
  localparam int AL = $clog2(ASYNC_DEPTH + 1);
  localparam int EL = $clog2(EDGE_DEPTH + 1);
  localparam int CW = EL + 1;
  localparam logic [CW-1:0] EDGE_CAP = CW'(EDGE_DEPTH);
  localparam logic [EL-1:0] TWO = EL'(2);
  localparam logic [EL-1:0] THREE = EL'(3);
  localparam logic [ddf_pkg::ROW_BITS-3:0] ROW_LAST = '1;
  logic ia_valid, ia_ready, ia_out_valid, ia_out_ready;
  logic [DW-1:0] ia_out_data;
  logic ir_wr_valid, ir_wr_ready, if_wr_valid, if_wr_ready;
  logic ir_rd_valid, if_rd_valid;
  logic [EL-1:0] ir_level, if_level;
  logic er_wr_ready, ef_wr_ready, er_rd_valid, ef_rd_valid, er_rd_ready, ef_rd_ready;
  logic [DW-1:0] er_data, ef_data;
  logic [EL-1:0] er_level, ef_level;
  logic eo_wr_valid, eo_wr_ready;
  logic [DW-1:0] eo_wr_data;
  ddf_pkg::ddf_state_t state;
  logic [PW-1:0] wr_ptr, rd_ptr, stored;
  logic [CW-1:0] inflight;
  logic buf_empty, buf_full, ctrl_enable, prefer_write, in_sel, out_sel;
  logic can_write, can_read, credit_ok, credit_more, mem_push, rd_fire, rd_pair_fire;
  logic [31:0] empty_hold, full_hold, beat_cnt;

  function automatic ddf_pkg::ddf_reg_t reg_decode(input logic [ddf_pkg::REG_AW-1:0] adr);
    ddf_pkg::ddf_reg_t r;
    case (adr)
      ddf_pkg::REG_CTRL: r = ddf_pkg::DDF_REG_CTRL;
      ddf_pkg::REG_STATUS: r = ddf_pkg::DDF_REG_STATUS;
      ddf_pkg::REG_LEVEL: r = ddf_pkg::DDF_REG_LEVEL;
      default: r = ddf_pkg::DDF_REG_NONE;
    endcase
    return r;
  endfunction
  assign stored = PW'(wr_ptr - rd_ptr);
  assign buf_empty = (stored == '0);
  assign buf_full = (stored == ddf_pkg::BUF_FULL_LEVEL);
  assign ia_valid = in_valid && !buf_full;
  assign in_ready = ia_ready && !buf_full;

  ddf_stage_fifo #(.WIDTH(DW), .DEPTH(ASYNC_DEPTH), .LW(AL)) u_in_stage (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .wr_valid(ia_valid), .wr_data(in_data), .wr_ready(ia_ready),
    .rd_valid(ia_out_valid), .rd_data(ia_out_data), .rd_ready(ia_out_ready),
    .level()
  );
  assign ir_wr_valid = ia_out_valid && !in_sel;
  assign if_wr_valid = ia_out_valid && in_sel;
  assign ia_out_ready = in_sel ? if_wr_ready : ir_wr_ready;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      in_sel <= 1'b0;
    end else if (clk_en && ia_out_valid && ia_out_ready) begin
      in_sel <= !in_sel;
    end
  end

  ddf_stage_fifo #(.WIDTH(DW), .DEPTH(EDGE_DEPTH), .LW(EL)) u_wr_rise (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .wr_valid(ir_wr_valid), .wr_data(ia_out_data), .wr_ready(ir_wr_ready),
    .rd_valid(ir_rd_valid), .rd_data(wr_rise_data), .rd_ready(mem_push),
    .level(ir_level)
  );

  ddf_stage_fifo #(.WIDTH(DW), .DEPTH(EDGE_DEPTH), .LW(EL)) u_wr_fall (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .wr_valid(if_wr_valid), .wr_data(ia_out_data), .wr_ready(if_wr_ready),
    .rd_valid(if_rd_valid), .rd_data(wr_fall_data), .rd_ready(mem_push),
    .level(if_level)
  );
  assign mem_push = clk_en && ir_rd_valid && if_rd_valid && wr_rise_ready && wr_fall_ready &&
                    ((state == ddf_pkg::DDF_S_WR_TAIL) ||
                     (state == ddf_pkg::DDF_S_WR_HEAD && wr_addr_ready));
  assign wr_rise_valid = mem_push;
  assign wr_fall_valid = mem_push;
  assign wr_addr_valid = mem_push && (state == ddf_pkg::DDF_S_WR_HEAD);
  assign wr_addr = wr_ptr[ddf_pkg::ADDR_W-1:0];
  assign credit_ok = (CW'(ef_level) + inflight + CW'(TWO)) <= EDGE_CAP;
  assign credit_more = (CW'(ef_level) + inflight + CW'(2 * TWO)) <= EDGE_CAP;
  assign rd_addr_valid = clk_en && (state == ddf_pkg::DDF_S_RD);
  assign rd_addr = rd_ptr[ddf_pkg::ADDR_W-1:0];
  assign rd_fire = rd_addr_valid && rd_addr_ready;

  assign can_write = ctrl_enable && !buf_full && (ir_level >= TWO) && (if_level >= TWO);
  assign can_read = ctrl_enable && !buf_empty && credit_ok;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= ddf_pkg::DDF_S_IDLE;
      prefer_write <= 1'b1;
    end else if (clk_en) begin
      case (state)
        ddf_pkg::DDF_S_IDLE: begin
          if (can_write && (prefer_write || !can_read)) begin
            state <= ddf_pkg::DDF_S_WR_HEAD;
            prefer_write <= 1'b0;
          end else if (can_read) begin
            state <= ddf_pkg::DDF_S_RD;
            prefer_write <= 1'b1;
          end
        end
        ddf_pkg::DDF_S_WR_HEAD: begin
          if (mem_push) begin
            state <= ddf_pkg::DDF_S_WR_TAIL;
          end
        end
        ddf_pkg::DDF_S_WR_TAIL: begin
          if (mem_push) begin
            if (ctrl_enable && (ir_level >= THREE) && (if_level >= THREE) &&
                (stored != PW'(ddf_pkg::BUF_FULL_LEVEL - ddf_pkg::BURST_WORDS)) &&
                (wr_ptr[ddf_pkg::ROW_BITS-1:2] != ROW_LAST)) begin
              state <= ddf_pkg::DDF_S_WR_HEAD;
            end else begin
              state <= ddf_pkg::DDF_S_IDLE;
            end
          end
        end
        ddf_pkg::DDF_S_RD: begin
          if (rd_fire) begin
            if (ctrl_enable && (stored != ddf_pkg::BURST_WORDS) && credit_more &&
                (rd_ptr[ddf_pkg::ROW_BITS-1:2] != ROW_LAST)) begin
              state <= ddf_pkg::DDF_S_RD;
            end else begin
              state <= ddf_pkg::DDF_S_IDLE;
            end
          end
        end
        default: state <= ddf_pkg::DDF_S_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clk_en) begin
      if (mem_push && state == ddf_pkg::DDF_S_WR_TAIL) begin
        wr_ptr <= PW'(wr_ptr + ddf_pkg::BURST_WORDS);
      end
      if (rd_fire) begin
        rd_ptr <= PW'(rd_ptr + ddf_pkg::BURST_WORDS);
      end
    end
  end
  assign rd_pair_fire = clk_en && rd_rise_valid && rd_fall_valid && er_wr_ready && ef_wr_ready;
  assign rd_rise_ready = rd_pair_fire;
  assign rd_fall_ready = rd_pair_fire;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      inflight <= '0;
    end else if (clk_en) begin
      inflight <= CW'(inflight + (rd_fire ? CW'(TWO) : '0) - (rd_pair_fire ? CW'(1) : '0));
    end
  end

  ddf_stage_fifo #(.WIDTH(DW), .DEPTH(EDGE_DEPTH), .LW(EL)) u_rd_rise (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .wr_valid(rd_pair_fire), .wr_data(rd_rise_data), .wr_ready(er_wr_ready),
    .rd_valid(er_rd_valid), .rd_data(er_data), .rd_ready(er_rd_ready),
    .level(er_level)
  );

  ddf_stage_fifo #(.WIDTH(DW), .DEPTH(EDGE_DEPTH), .LW(EL)) u_rd_fall (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .wr_valid(rd_pair_fire), .wr_data(rd_fall_data), .wr_ready(ef_wr_ready),
    .rd_valid(ef_rd_valid), .rd_data(ef_data), .rd_ready(ef_rd_ready),
    .level(ef_level)
  );
  assign eo_wr_valid = out_sel ? ef_rd_valid : er_rd_valid;
  assign eo_wr_data = out_sel ? ef_data : er_data;
  assign er_rd_ready = !out_sel && eo_wr_ready;
  assign ef_rd_ready = out_sel && eo_wr_ready;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      out_sel <= 1'b0;
    end else if (clk_en && eo_wr_valid && eo_wr_ready) begin
      out_sel <= !out_sel;
    end
  end

  ddf_stage_fifo #(.WIDTH(DW), .DEPTH(ASYNC_DEPTH), .LW(AL)) u_out_stage (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .wr_valid(eo_wr_valid), .wr_data(eo_wr_data), .wr_ready(eo_wr_ready),
    .rd_valid(out_valid), .rd_data(out_data), .rd_ready(out_ready),
    .level()
  );

  // Indicators; status shares sys_clk, so no crossing is needed
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      empty_hold <= '0;
    end else if (clk_en) begin
      if (buf_empty) begin
        empty_hold <= LED_HOLD;
      end else if (empty_hold != '0) begin
        empty_hold <= empty_hold - 32'h00000001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      full_hold <= '0;
    end else if (clk_en) begin
      if (buf_full) begin
        full_hold <= LED_HOLD;
      end else if (full_hold != '0) begin
        full_hold <= full_hold - 32'h00000001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      beat_cnt <= '0;
      led_heartbeat <= 1'b0;
    end else if (clk_en) begin
      if (beat_cnt >= HEARTBEAT_HALF - 1) begin
        beat_cnt <= '0;
        led_heartbeat <= !led_heartbeat;
      end else begin
        beat_cnt <= beat_cnt + 32'h00000001;
      end
    end
  end

  assign led_empty = (empty_hold != '0);
  assign led_full = (full_hold != '0);

  // Wishbone slave: ack one cycle after the strobe, unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (clk_en) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= '0;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        case (reg_decode(wb_adr_i))
          ddf_pkg::DDF_REG_CTRL: wb_dat_o[ddf_pkg::CTRL_ENABLE_BIT] <= ctrl_enable;
          ddf_pkg::DDF_REG_STATUS: begin
            wb_dat_o[ddf_pkg::STAT_EMPTY_BIT] <= buf_empty;
            wb_dat_o[ddf_pkg::STAT_FULL_BIT] <= buf_full;
            wb_dat_o[ddf_pkg::STAT_BUSY_BIT] <= (state != ddf_pkg::DDF_S_IDLE);
            wb_dat_o[ddf_pkg::STAT_LED_EMPTY_BIT] <= led_empty;
            wb_dat_o[ddf_pkg::STAT_LED_FULL_BIT] <= led_full;
          end
          ddf_pkg::DDF_REG_LEVEL: wb_dat_o[PW-1:0] <= stored;
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_enable <= ddf_pkg::CTRL_ENABLE_RST;
    end else if (clk_en && wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
                 reg_decode(wb_adr_i) == ddf_pkg::DDF_REG_CTRL) begin
      ctrl_enable <= wb_dat_i[ddf_pkg::CTRL_ENABLE_BIT];
    end
  end
endmodule
`default_nettype wire

// [dv/ddf_top_assertions.sv]
// Concurrent checks on the ports of the memory-backed deep FIFO top.
// Assumes one clock with srst synchronous; bound into every ddf_top.
`timescale 1ns/10ps
`default_nettype none
module ddf_top_assertions #(
  parameter int unsigned HEARTBEAT_HALF = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic wr_addr_valid,
  input wire logic [ddf_pkg::ADDR_W-1:0] wr_addr,
  input wire logic wr_addr_ready,
  input wire logic wr_rise_valid,
  input wire logic wr_rise_ready,
  input wire logic wr_fall_valid,
  input wire logic rd_addr_valid,
  input wire logic [ddf_pkg::ADDR_W-1:0] rd_addr,
  input wire logic rd_addr_ready,
  input wire logic rd_rise_ready,
  input wire logic rd_fall_ready,
  input wire logic led_empty,
  input wire logic led_heartbeat
);
  logic [24:0] next_wa;
  logic wa_seen;
  int stored;
  int unsigned hb_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Words handed to memory minus words requested back
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wa_seen <= 1'b0;
      next_wa <= '0;
      stored <= 0;
    end else begin
      if (wr_addr_valid && wr_addr_ready) begin
        wa_seen <= 1'b1;
        next_wa <= wr_addr + 25'h4;
      end
      stored <= stored + ((wr_rise_valid && wr_rise_ready) ? 2 : 0) - ((rd_addr_valid && rd_addr_ready) ? 4 : 0);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst || $changed(led_heartbeat)) begin
      hb_cnt <= 0;
    end else if (clk_en) begin
      hb_cnt <= hb_cnt + 1;
    end
  end
  sequence head_push;
    wr_addr_valid && wr_addr_ready && wr_rise_valid && wr_rise_ready;
  endsequence
  sequence tail_push;
    wr_rise_valid && wr_rise_ready && !wr_addr_valid;
  endsequence
  chk_wb_ack_next: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en) |=> wb_ack_o)
    else $error("ack late");
  chk_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_wb_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("stale read data");
  chk_rw_exclusive: assert property (!(rd_addr_valid && (wr_addr_valid || wr_rise_valid)))
    else $error("read and write together");
  chk_edge_pairs: assert property (wr_rise_valid == wr_fall_valid && rd_rise_ready == rd_fall_ready)
    else $error("edges unpaired");
  chk_burst_tail: assert property (head_push |-> ##[1:300] tail_push)
    else $error("burst tail missing");
  chk_addr_step: assert property (wr_addr_valid && wr_addr_ready && wa_seen |-> wr_addr == next_wa)
    else $error("bad write address step");
  chk_addr_align: assert property (!(wr_addr_valid && wr_addr[1:0] != 2'h0) && !(rd_addr_valid && rd_addr[1:0] != 2'h0))
    else $error("unaligned burst");
  chk_rd_stored: assert property (rd_addr_valid |-> stored >= 4)
    else $error("read while empty");
  chk_rd_hold: assert property (rd_addr_valid && !rd_addr_ready |=> !clk_en || (rd_addr_valid && $stable(rd_addr)))
    else $error("read request dropped");
  chk_freeze_hs: assert property (!clk_en |-> !in_ready && !out_valid && !wr_rise_valid && !rd_addr_valid)
    else $error("handshake while frozen");
  chk_hb_period: assert property ($changed(led_heartbeat) |-> hb_cnt >= HEARTBEAT_HALF - 2 && hb_cnt <= HEARTBEAT_HALF)
    else $error("heartbeat period");
  chk_hb_alive: assert property (hb_cnt <= HEARTBEAT_HALF)
    else $error("heartbeat stuck");
  chk_empty_led: assert property ($fell(srst) |=> led_empty [*8])
    else $error("empty led dark");
endmodule
bind ddf_top ddf_top_assertions #(.HEARTBEAT_HALF(HEARTBEAT_HALF)) ddf_top_assertions_i (.sys_clk, .srst, .clk_en,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .in_ready, .out_valid, .wr_addr_valid, .wr_addr, .wr_addr_ready,
  .wr_rise_valid, .wr_rise_ready, .wr_fall_valid, .rd_addr_valid, .rd_addr, .rd_addr_ready, .rd_rise_ready,
  .rd_fall_ready, .led_empty, .led_heartbeat);
`default_nettype wire

// [dv/ddf_mem_model.sv]
// Behavioural memory interface: write address and edge data FIFOs, read returns.
// Assumes sys_clk; slow high delays readies and returns at random.
`timescale 1ns/10ps
`default_nettype none
module ddf_mem_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic wr_addr_valid,
  input wire logic [ddf_pkg::ADDR_W-1:0] wr_addr,
  output logic wr_addr_ready,
  input wire logic wr_rise_valid,
  input wire logic [31:0] wr_rise_data,
  output logic wr_rise_ready,
  input wire logic wr_fall_valid,
  input wire logic [31:0] wr_fall_data,
  output logic wr_fall_ready,
  input wire logic rd_addr_valid,
  input wire logic [ddf_pkg::ADDR_W-1:0] rd_addr,
  output logic rd_addr_ready,
  output logic rd_rise_valid,
  output logic [31:0] rd_rise_data,
  input wire logic rd_rise_ready,
  output logic rd_fall_valid,
  output logic [31:0] rd_fall_data,
  input wire logic rd_fall_ready
);
  logic [31:0] mem [int unsigned];
  int unsigned wa;
  int unsigned rq[$];
  always @(posedge sys_clk) begin
    wr_addr_ready <= !slow || ($urandom % 2 == 0);
    wr_rise_ready <= !slow || ($urandom % 2 == 0);
    wr_fall_ready <= !slow || ($urandom % 2 == 0);
    rd_addr_ready <= !slow || ($urandom % 2 == 0);
    if (srst) begin
      rq.delete();
      rd_rise_valid <= 1'b0;
      rd_fall_valid <= 1'b0;
      rd_rise_data <= 32'h5a5a5a5a;
      rd_fall_data <= 32'ha5a5a5a5;
    end else begin
      if (wr_addr_valid && wr_addr_ready) wa = wr_addr;
      if (wr_rise_valid && wr_rise_ready && wr_fall_valid && wr_fall_ready) begin
        mem[wa] = wr_rise_data;
        mem[wa + 1] = wr_fall_data;
        wa += 2;
      end
      if (rd_addr_valid && rd_addr_ready) begin
        rq.push_back(rd_addr);
        rq.push_back(rd_addr + 2);
      end
      if (rd_rise_valid && rd_rise_ready && rd_fall_ready) void'(rq.pop_front());
      if (!rd_rise_valid || rd_rise_ready) begin
        if (rq.size() > 0 && (!slow || $urandom % 2 == 0)) begin
          rd_rise_valid <= 1'b1;
          rd_fall_valid <= 1'b1;
          rd_rise_data <= mem[rq[0]];
          rd_fall_data <= mem[rq[0] + 1];
        end else begin
          rd_rise_valid <= 1'b0;
          rd_fall_valid <= 1'b0;
          rd_rise_data <= ~rd_rise_data;
          rd_fall_data <= ~rd_fall_data;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [dv/ddr_backed_deep_fifo_bench.sv]
// Self-checking bench: word order model, register reads, stalls and freeze.
// Assumes short indicator counts and the memory model.
`timescale 1ns/10ps
`default_nettype none
module ddr_backed_deep_fifo_bench;
  logic sys_clk, srst, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, in_valid, in_ready, out_valid, out_ready;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, in_data, out_data, wr_rise_data, wr_fall_data, rd_rise_data, rd_fall_data, q;
  logic [24:0] wr_addr, rd_addr;
  logic wr_addr_valid, wr_addr_ready, wr_rise_valid, wr_rise_ready, wr_fall_valid, wr_fall_ready;
  logic rd_addr_valid, rd_addr_ready, rd_rise_valid, rd_rise_ready, rd_fall_valid, rd_fall_ready;
  logic led_empty, led_full, led_heartbeat, slow, drain;
  logic [31:0] ref_q[$];
  int bad_count, tests_run, n_left;
  ddf_top #(.LED_HOLD(8), .HEARTBEAT_HALF(4)) ddf_top_i (.sys_clk, .srst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .in_valid, .in_data, .in_ready, .out_valid, .out_data,
    .out_ready, .wr_addr_valid, .wr_addr, .wr_addr_ready, .wr_rise_valid, .wr_rise_data, .wr_rise_ready,
    .wr_fall_valid, .wr_fall_data, .wr_fall_ready, .rd_addr_valid, .rd_addr, .rd_addr_ready, .rd_rise_valid,
    .rd_rise_data, .rd_rise_ready, .rd_fall_valid, .rd_fall_data, .rd_fall_ready, .led_empty, .led_full,
    .led_heartbeat);
  ddf_mem_model ddf_mem_model_i (.sys_clk, .srst, .slow, .wr_addr_valid, .wr_addr, .wr_addr_ready, .wr_rise_valid,
    .wr_rise_data, .wr_rise_ready, .wr_fall_valid, .wr_fall_data, .wr_fall_ready, .rd_addr_valid, .rd_addr,
    .rd_addr_ready, .rd_rise_valid, .rd_rise_data, .rd_rise_ready, .rd_fall_valid, .rd_fall_data, .rd_fall_ready);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic stop_test;
    $display("checks run %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    tests_run++;
    if (got !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk("wb_ack_lat", 32'h2, 32'(n));
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 4'hf, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic settle(input int lim);
    int n;
    n = 0;
    while ((n_left != 0 || in_valid || ref_q.size() != 0) && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    chk("drained", 32'h0, 32'(ref_q.size() + n_left + in_valid));
  endtask
  // Ingress source and egress sink with random gaps
  always @(posedge sys_clk) begin
    out_ready <= drain && ($urandom % 4 != 0);
    if (!in_valid || in_ready) begin
      if (n_left > 0 && $urandom % 4 != 0) begin
        in_valid <= 1'b1;
        in_data <= $urandom;
        n_left--;
      end else begin
        in_valid <= 1'b0;
        in_data <= ~in_data;
      end
    end
  end
  always @(posedge sys_clk) begin
    if (!srst && in_valid && in_ready) ref_q.push_back(in_data);
    if (!srst && out_valid && out_ready) begin
      if (ref_q.size() == 0) chk("out_extra", 32'h0, 32'h1);
      else chk("out_data", ref_q.pop_front(), out_data);
    end
  end
  initial begin
    #240000;
    bad_count++;
    stop_test;
  end
  initial begin
    void'($urandom(42544));
    {bad_count, tests_run, n_left} = '0;
    {srst, clk_en} = 2'b11;
    {wb_cyc_i, wb_stb_i, wb_we_i, in_valid, out_ready, slow, drain} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, in_data} = '0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    rd_chk(8'h00, 32'h1, "ctrl");
    rd_chk(8'h04, 32'h9, "status");
    rd_chk(8'h08, 32'h0, "level");
    rd_chk(8'h0c, 32'h0, "unmapped");
    wb(1'b1, 8'h08, 4'hf, 32'h55);
    wb(1'b1, 8'h00, 4'he, 32'h0);
    rd_chk(8'h00, 32'h1, "ctrl_sel");
    rd_chk(8'h08, 32'h0, "level_ro");
    $display("test registers done");
    drain = 1'b1;
    n_left = 64;
    settle(4000);
    $display("test prompt stream done");
    slow = 1'b1;
    drain = 1'b0;
    n_left = 100;
    repeat (800) @(posedge sys_clk);
    wb(1'b0, 8'h08, 4'hf, 32'h0);
    chk("level_align", 32'h0, {30'h0, q[1:0]});
    chk("level_range", 32'h1, {31'h0, q >= 32'd53 && q <= 32'd100});
    chk("led_empty_off", 32'h0, {31'h0, led_empty});
    clk_en <= 1'b0;
    repeat (20) begin
      @(posedge sys_clk);
      chk("frozen", 32'h0, {28'h0, in_ready, out_valid, wr_rise_valid, rd_addr_valid});
    end
    clk_en <= 1'b1;
    drain = 1'b1;
    settle(8000);
    repeat (20) @(posedge sys_clk);
    chk("led_empty_on", 32'h1, {31'h0, led_empty});
    chk("led_full", 32'h0, {31'h0, led_full});
    $display("test slow partner and freeze done");
    wb(1'b1, 8'h00, 4'h1, 32'h0);
    slow = 1'b0;
    n_left = 8;
    repeat (100) @(posedge sys_clk);
    rd_chk(8'h08, 32'h0, "level_off");
    chk("out_idle", 32'h0, {31'h0, out_valid});
    wb(1'b1, 8'h00, 4'h1, 32'h1);
    settle(2000);
    $display("test burst enable done");
    stop_test;
  end
endmodule
`default_nettype wire
